/* inc/avg_filter_pkg.sv */
// constants, types and helpers for the oversampling average filter
// assumes a single 25 MHz clock domain and an asynchronous active-low reset
`default_nettype none

package avg_filter_pkg;

  // ---------------------------------------------------------------
  // sizes
  // ---------------------------------------------------------------
  localparam int unsigned CHANNELS   = 8;
  localparam int unsigned SAMPLE_W   = 18;
  localparam int unsigned OS_W       = 3;
  localparam int unsigned SHIFT_MAX  = 6;
  localparam int unsigned ACC_W      = SAMPLE_W + SHIFT_MAX;
  localparam int unsigned COUNT_W    = SHIFT_MAX + 1;
  localparam int unsigned FIFO_DEPTH = 16;
  localparam int unsigned TIMER_W    = 8;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int unsigned CLOCK_PERIOD_NS   = 40;
  localparam int unsigned SAMPLE_PERIOD_NS  = 4000;
  localparam int unsigned SAMPLE_PERIOD_CYC = (SAMPLE_PERIOD_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam logic [TIMER_W-1:0] GAP_RELOAD = TIMER_W'(SAMPLE_PERIOD_CYC - 1);
  // host-side rate ceiling in kHz without oversampling, for reference only; the bench does not use it
  localparam int unsigned MAX_RATE_NO_OS_KHZ = 200;

  // ---------------------------------------------------------------
  // codes and reset values
  // ---------------------------------------------------------------
  localparam logic [OS_W-1:0] OS_INVALID     = 3'h7;
  localparam logic [OS_W-1:0] OS_RESET       = 3'h0;
  localparam logic [OS_W-1:0] SHIFT_RESET    = 3'h0;
  localparam logic [COUNT_W-1:0] COUNT_RESET = 7'h00;

  typedef enum {ST_IDLE, ST_STROBE, ST_GATHER, ST_DONE} seq_state_t;

  // invalid code falls back to no oversampling
  function automatic logic [OS_W-1:0] shift_of(input logic [OS_W-1:0] code);
    return (code == OS_INVALID) ? 3'h0 : code;
  endfunction

  function automatic logic [COUNT_W-1:0] ratio_of(input logic [OS_W-1:0] shift);
    return COUNT_W'(7'h01 << shift);
  endfunction

endpackage

`default_nettype wire

/* hw/sample_fifo.sv */
// flip-flop fifo between the converter's channel words and the accumulator
// assumes push and pop come from logic on the same clock
`default_nettype none

module sample_fifo #(
  parameter int unsigned WIDTH = 18,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic             clock,
  input  wire logic             arst_n,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output var  logic             in_ready,
  output var  logic [WIDTH-1:0] out_data,
  output var  logic             out_valid,
  input  wire logic             out_ready
);

  localparam int unsigned PTR_W = $clog2(DEPTH);
  localparam int unsigned CNT_W = $clog2(DEPTH + 1);
  localparam logic [CNT_W-1:0] FULL_COUNT = CNT_W'(DEPTH);
  localparam logic [PTR_W-1:0] LAST_PTR   = PTR_W'(DEPTH - 1);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PTR_W-1:0] wr_q;
  logic [PTR_W-1:0] rd_q;
  logic [CNT_W-1:0] count_q;
  logic [CNT_W-1:0] count_d;
  logic             in_ready_q;
  wire              push = in_valid && in_ready_q;
  wire              pop  = out_valid && out_ready;

  assign count_d   = count_q + CNT_W'(push) - CNT_W'(pop);
  assign in_ready  = in_ready_q;
  assign out_valid = (count_q != '0);
  assign out_data  = mem_q[rd_q];

  always_ff @(posedge clock) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  // ready is registered from the next count so the source sees a flop and every slot stays usable
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      wr_q       <= '0;
      rd_q       <= '0;
      count_q    <= '0;
      in_ready_q <= 1'b0;
    end else begin
      wr_q       <= push ? ((wr_q == LAST_PTR) ? '0 : wr_q + PTR_W'(1)) : wr_q;
      rd_q       <= pop ? ((rd_q == LAST_PTR) ? '0 : rd_q + PTR_W'(1)) : rd_q;
      count_q    <= count_d;
      in_ready_q <= (count_d != FULL_COUNT);
    end
  end

endmodule

`default_nettype wire

/* hw/oversampling_average_filter.sv */
// conversion sequencer and averaging filter for eight simultaneous channels
// assumes convert starts and ratio select arrive as asynchronous pins and
// channel words arrive in channel order after every sample strobe
`default_nettype none

module oversampling_average_filter #(
  parameter int unsigned CHANNELS   = avg_filter_pkg::CHANNELS,
  parameter int unsigned SAMPLE_W   = avg_filter_pkg::SAMPLE_W,
  parameter int unsigned FIFO_DEPTH = avg_filter_pkg::FIFO_DEPTH
) (
  input  wire logic                           clock,
  input  wire logic                           arst_n,
  input  wire logic                           convert_start_a,
  input  wire logic                           convert_start_b,
  input  wire logic [avg_filter_pkg::OS_W-1:0] oversample_select,
  input  wire logic [SAMPLE_W-1:0]            sample_data,
  input  wire logic                           sample_valid,
  output var  logic                           sample_ready,
  output var  logic                           sample_strobe,
  output var  logic                           busy,
  output var  logic [CHANNELS*SAMPLE_W-1:0]   result
);

  localparam int unsigned ACC_W   = SAMPLE_W + avg_filter_pkg::SHIFT_MAX;
  localparam int unsigned COUNT_W = avg_filter_pkg::COUNT_W;
  localparam int unsigned CH_W    = $clog2(CHANNELS);
  localparam logic [CH_W-1:0] LAST_CH = CH_W'(CHANNELS - 1);

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic                            cs_a_meta_q, cs_a_sync_q, cs_a_prev_q;
  logic                            cs_b_meta_q, cs_b_sync_q, cs_b_prev_q;
  logic [avg_filter_pkg::OS_W-1:0] os_meta_q, os_sync_q;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cs_a_meta_q <= 1'b0;
      cs_a_sync_q <= 1'b0;
      cs_a_prev_q <= 1'b0;
      cs_b_meta_q <= 1'b0;
      cs_b_sync_q <= 1'b0;
      cs_b_prev_q <= 1'b0;
      os_meta_q   <= avg_filter_pkg::OS_RESET;
      os_sync_q   <= avg_filter_pkg::OS_RESET;
    end else begin
      cs_a_meta_q <= convert_start_a;
      cs_a_sync_q <= cs_a_meta_q;
      cs_a_prev_q <= cs_a_sync_q;
      cs_b_meta_q <= convert_start_b;
      cs_b_sync_q <= cs_b_meta_q;
      cs_b_prev_q <= cs_b_sync_q;
      os_meta_q   <= oversample_select;
      os_sync_q   <= os_meta_q;
    end
  end

  // either input starts; with oversampling the host drives both alike
  wire start_edge = (cs_a_sync_q && !cs_a_prev_q) || (cs_b_sync_q && !cs_b_prev_q);

  // ---------------------------------------------------------------
  // channel word fifo
  // ---------------------------------------------------------------
  logic [SAMPLE_W-1:0] word_data;
  logic                word_valid;
  logic                word_ready;

  sample_fifo #(
    .WIDTH (SAMPLE_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clock     (clock),
    .arst_n    (arst_n),
    .in_data   (sample_data),
    .in_valid  (sample_valid),
    .in_ready  (sample_ready),
    .out_data  (word_data),
    .out_valid (word_valid),
    .out_ready (word_ready)
  );

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  avg_filter_pkg::seq_state_t      state_q;
  logic [avg_filter_pkg::OS_W-1:0] shift_q;
  logic [avg_filter_pkg::TIMER_W-1:0] gap_q;
  logic [CH_W-1:0]                 ch_q;
  logic [COUNT_W-1:0]              strobes_q;
  logic [COUNT_W-1:0]              taken_q;
  logic                            busy_q;
  logic                            strobe_q;
  logic signed [ACC_W-1:0]         acc_q [CHANNELS];
  logic [CHANNELS*SAMPLE_W-1:0]    result_q;

  wire [COUNT_W-1:0] target     = avg_filter_pkg::ratio_of(shift_q);
  wire               group_done = (taken_q == strobes_q);
  wire               in_gather  = (state_q == avg_filter_pkg::ST_GATHER);
  // words are held in the fifo until a strobe is outstanding
  assign word_ready = in_gather && !group_done;
  wire               take      = word_valid && word_ready;
  wire signed [ACC_W-1:0] word_ext = ACC_W'(signed'(word_data));

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_q   <= avg_filter_pkg::ST_IDLE;
      shift_q   <= avg_filter_pkg::SHIFT_RESET;
      gap_q     <= '0;
      strobes_q <= avg_filter_pkg::COUNT_RESET;
      busy_q    <= 1'b0;
      strobe_q  <= 1'b0;
    end else begin
      strobe_q <= 1'b0;
      gap_q    <= (gap_q != '0) ? gap_q - 1'b1 : gap_q;
      unique case (state_q)
        avg_filter_pkg::ST_IDLE: begin
          if (start_edge) begin
            state_q   <= avg_filter_pkg::ST_STROBE;
            busy_q    <= 1'b1;
            strobes_q <= avg_filter_pkg::COUNT_RESET;
          end
        end
        avg_filter_pkg::ST_STROBE: begin
          strobe_q  <= 1'b1;
          strobes_q <= strobes_q + 1'b1;
          gap_q     <= avg_filter_pkg::GAP_RELOAD;
          state_q   <= avg_filter_pkg::ST_GATHER;
        end
        avg_filter_pkg::ST_GATHER: begin
          if (group_done && strobes_q == target) begin
            state_q <= avg_filter_pkg::ST_DONE;
          end else if (group_done && gap_q == '0) begin
            state_q <= avg_filter_pkg::ST_STROBE;
          end
        end
        avg_filter_pkg::ST_DONE: begin
          busy_q  <= 1'b0;
          shift_q <= avg_filter_pkg::shift_of(os_sync_q);
          state_q <= avg_filter_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // accumulation and averaging
  // ---------------------------------------------------------------
  // six guard bits hold a sum of 64 full-scale samples without overflow
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ch_q    <= '0;
      taken_q <= avg_filter_pkg::COUNT_RESET;
      for (int c = 0; c < CHANNELS; c++) begin
        acc_q[c] <= '0;
      end
    end else if (state_q == avg_filter_pkg::ST_IDLE) begin
      ch_q    <= '0;
      taken_q <= avg_filter_pkg::COUNT_RESET;
      for (int c = 0; c < CHANNELS; c++) begin
        acc_q[c] <= '0;
      end
    end else if (take) begin
      acc_q[ch_q] <= acc_q[ch_q] + word_ext;
      ch_q        <= (ch_q == LAST_CH) ? '0 : ch_q + 1'b1;
      taken_q     <= (ch_q == LAST_CH) ? taken_q + 1'b1 : taken_q;
    end
  end

  logic [CHANNELS*SAMPLE_W-1:0] mean_w;

  for (genvar c = 0; c < CHANNELS; c++) begin : g_mean
    wire signed [ACC_W-1:0] shifted = acc_q[c] >>> shift_q;
    assign mean_w[c*SAMPLE_W +: SAMPLE_W] = shifted[SAMPLE_W-1:0];
  end

  // results only move on the busy fall, so reads while busy see the previous set
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      result_q <= '0;
    end else if (state_q == avg_filter_pkg::ST_DONE) begin
      result_q <= mean_w;
    end
  end

  assign sample_strobe = strobe_q;
  assign busy          = busy_q;
  assign result        = result_q;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence s_quiet_after_strobe;
    !strobe_q [*8];
  endsequence

  sequence s_start_to_strobe;
    ##1 (state_q == avg_filter_pkg::ST_STROBE) ##1 strobe_q;
  endsequence

  property p_result_at_fall;
    @(posedge clock) disable iff (!arst_n) $changed(result_q) |-> $fell(busy_q);
  endproperty
  a_result_at_fall: assert property (p_result_at_fall) else $error("result moved outside busy fall");

  property p_ratio_at_fall;
    @(posedge clock) disable iff (!arst_n) $changed(shift_q) |-> $fell(busy_q);
  endproperty
  a_ratio_at_fall: assert property (p_ratio_at_fall) else $error("ratio latched outside busy fall");

  property p_ratio_decode;
    @(posedge clock) disable iff (!arst_n)
      $fell(busy_q) |-> shift_q == (($past(os_sync_q) == 3'h7) ? 3'h0 : $past(os_sync_q));
  endproperty
  a_ratio_decode: assert property (p_ratio_decode) else $error("select code decoded wrongly");

  property p_bit_order;
    @(posedge clock) disable iff (!arst_n)
      $fell(busy_q) && $past(os_sync_q) == 3'h4 |-> shift_q == 3'h4;
  endproperty
  a_bit_order: assert property (p_bit_order) else $error("select bit order reversed");

  property p_first_sample;
    @(posedge clock) disable iff (!arst_n)
      (state_q == avg_filter_pkg::ST_IDLE) && start_edge |-> s_start_to_strobe;
  endproperty
  a_first_sample: assert property (p_first_sample) else $error("no sample strobe after convert edge");

  property p_strobe_spacing;
    @(posedge clock) disable iff (!arst_n) strobe_q |=> s_quiet_after_strobe;
  endproperty
  a_strobe_spacing: assert property (p_strobe_spacing) else $error("internal strobes too close");

  property p_sample_count;
    @(posedge clock) disable iff (!arst_n)
      $fell(busy_q) |-> strobes_q == (7'h01 << $past(shift_q)) && taken_q == strobes_q;
  endproperty
  a_sample_count: assert property (p_sample_count) else $error("wrong number of samples averaged");

  property p_busy_holds;
    @(posedge clock) disable iff (!arst_n)
      busy_q && (strobes_q != target || !group_done) |=> busy_q;
  endproperty
  a_busy_holds: assert property (p_busy_holds) else $error("busy fell before all samples");

  property p_mean_ch0;
    @(posedge clock) disable iff (!arst_n)
      $fell(busy_q) |-> result_q[SAMPLE_W-1:0] == $past(mean_w[SAMPLE_W-1:0]);
  endproperty
  a_mean_ch0: assert property (p_mean_ch0) else $error("channel 0 result is not the mean");

endmodule

`default_nettype wire

/* bench/converter_model.sv */
// converter stand-in: answers each sample strobe with one word per channel
// assumes the bench loads words in channel order before a conversion
`default_nettype none

module converter_model (
  input  wire logic                                clock,
  input  wire logic                                arst_n,
  input  wire logic                                sample_strobe,
  input  wire logic                                sample_ready,
  output var  logic [avg_filter_pkg::SAMPLE_W-1:0] sample_data,
  output var  logic                                sample_valid
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [avg_filter_pkg::SAMPLE_W-1:0] words_q[$];
  int                                  ahead    = 0;
  int                                  seed     = 30;
  int                                  fill_req = 0;
  int                                  fill_ack = 0;
  int                                  filled   = 0;

  task automatic load(input logic [avg_filter_pkg::SAMPLE_W-1:0] w);
    words_q.push_back(w);
  endtask

  // push words before any strobe until the buffer refuses one; the strobe
  // process does the pushing so the stream keeps a single driver
  task automatic fill(output int n);
    fill_req++;
    wait (fill_ack == fill_req);
    n = filled;
  endtask

  // ---------------------------------------------------------------
  // strobe answer, with random stalls between words
  // ---------------------------------------------------------------
  initial begin
    logic [avg_filter_pkg::SAMPLE_W-1:0] w;
    sample_valid = 1'b0;
    sample_data  = '0;
    forever begin
      @(posedge clock);
      if (fill_ack != fill_req) begin
        filled = 0;
        sample_valid <= 1'b1;
        sample_data  <= words_q[0];
        forever begin
          @(posedge clock);
          if (sample_ready !== 1'b1) break;
          void'(words_q.pop_front());
          filled++;
          sample_data <= words_q[0];
        end
        ahead += filled;
        sample_valid <= 1'b0;
        sample_data  <= ~words_q[0];
        fill_ack++;
      end else if (arst_n === 1'b1 && sample_strobe === 1'b1 && ahead >= 8) begin
        // sets pushed early are already buffered, so skip them
        ahead -= 8;
      end else if (arst_n === 1'b1 && sample_strobe === 1'b1) begin
        for (int k = 0; k < 8; k++) begin
          w = words_q.pop_front();
          sample_valid <= 1'b1;
          sample_data  <= w;
          do @(posedge clock); while (sample_ready !== 1'b1);
          // released data is inverted so a stale word never looks valid
          if (k == 7 || $random(seed) % 3 == 0) begin
            sample_valid <= 1'b0;
            sample_data  <= ~w;
            @(posedge clock);
          end
        end
      end
    end
  end
endmodule

`default_nettype wire

/* bench/oversampling_average_filter_tb_top.sv */
// self-checking bench for the oversampling average filter
// assumes the converter model answers strobes; expectations are its own sums
`default_nettype none

module oversampling_average_filter_tb_top;
  timeunit 1ns;
  timeprecision 1ns;

  localparam int unsigned W  = avg_filter_pkg::SAMPLE_W;
  localparam int unsigned CH = avg_filter_pkg::CHANNELS;
  localparam logic [2:0]  CODES [9] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7, 3'h2, 3'h0};

  logic            clock;
  logic            arst_n;
  logic            convert_start_a;
  logic            convert_start_b;
  logic [2:0]      oversample_select;
  logic [W-1:0]    sample_data;
  logic            sample_valid;
  logic            sample_ready;
  logic            sample_strobe;
  logic            busy;
  logic [CH*W-1:0] result;
  int              fails    = 0;
  int              compares = 0;
  int              seed     = 30;
  int              cycles   = 0;

  oversampling_average_filter oversampling_average_filter_i (
    .clock(clock), .arst_n(arst_n), .convert_start_a(convert_start_a), .convert_start_b(convert_start_b),
    .oversample_select(oversample_select), .sample_data(sample_data), .sample_valid(sample_valid),
    .sample_ready(sample_ready), .sample_strobe(sample_strobe), .busy(busy), .result(result));

  converter_model converter_model_i (
    .clock(clock), .arst_n(arst_n), .sample_strobe(sample_strobe), .sample_ready(sample_ready),
    .sample_data(sample_data), .sample_valid(sample_valid));

  task automatic check(input string what, input logic [CH*W-1:0] seen, input logic [CH*W-1:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic summarize();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  function automatic int shift_for(input logic [2:0] code);
    return (code == 3'h7) ? 0 : int'(code);
  endfunction

  // floor of the signed mean: arithmetic shift of the exact sum
  function automatic logic [W-1:0] mean_of(input int total, input int shift);
    return W'(total >>> shift);
  endfunction

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  // a hang counts as a mismatch
  always @(posedge clock) begin
    cycles++;
    if (cycles >= 40000) begin
      fails++;
      summarize();
    end
  end

  // ---------------------------------------------------------------
  // one conversion at a given shift, selecting next_code meanwhile
  // ---------------------------------------------------------------
  task automatic run_conv(input int shift, input logic [2:0] next_code, input bit do_fill);
    int              n;
    int              strobes;
    int              filled;
    int              sum [CH];
    logic [W-1:0]    w;
    logic [CH*W-1:0] old;
    logic            ok;
    n = 1 << shift;
    strobes = 0;
    for (int c = 0; c < CH; c++) sum[c] = 0;
    for (int j = 0; j < n; j++) begin
      for (int c = 0; c < CH; c++) begin
        w = W'($random(seed));
        // extreme codes stress the accumulator width
        if (shift == 6 && c < 2) w = (c == 0) ? 18'h1ffff : 18'h20000;
        sum[c] += int'($signed(w));
        converter_model_i.load(w);
      end
    end
    @(posedge clock);
    oversample_select <= next_code;
    if (do_fill) begin
      converter_model_i.fill(filled);
      #1;
      check("fill count", filled, avg_filter_pkg::FIFO_DEPTH);
      check("ready when full", sample_ready, 1'b0);
    end
    @(posedge clock);
    convert_start_a <= 1'b1;
    convert_start_b <= 1'b1;
    ok = 1'b0;
    for (int k = 0; k < 10 && !ok; k++) begin
      @(posedge clock);
      #1;
      ok = (busy === 1'b1);
    end
    check("busy rise", ok, 1'b1);
    old = result;
    for (int k = 0; k < 8000 && busy === 1'b1; k++) begin
      @(posedge clock);
      if (k == 0 || k == 24) begin
        convert_start_a <= 1'b0;
        convert_start_b <= 1'b0;
      end
      // a second start while busy must be ignored
      if (k == 20 && shift > 0) begin
        convert_start_a <= 1'b1;
        convert_start_b <= 1'b1;
      end
      #1;
      if (sample_strobe === 1'b1) strobes++;
      if (busy === 1'b1 && result !== old) ok = 1'b0;
    end
    check("result steady in busy", ok, 1'b1);
    check("busy fall", busy, 1'b0);
    check("strobes", strobes, n);
    @(posedge clock);
    #1;
    for (int c = 0; c < CH; c++) begin
      check("channel mean", result[c*W +: W], mean_of(sum[c], shift));
    end
    repeat (6) @(posedge clock);
    #1;
    check("busy after ignored start", busy, 1'b0);
  endtask

  initial begin
    int prev;
    arst_n            = 1'b0;
    convert_start_a   = 1'b0;
    convert_start_b   = 1'b0;
    oversample_select = 3'h0;
    repeat (8) @(posedge clock);
    #1;
    check("busy in reset", busy, 1'b0);
    check("strobe in reset", sample_strobe, 1'b0);
    check("result in reset", result, '0);
    check("ready in reset", sample_ready, 1'b0);
    @(posedge clock);
    arst_n <= 1'b1;
    @(posedge clock);
    #1;
    check("ready after reset", sample_ready, 1'b1);
    // each conversion runs at the ratio chosen during the one before
    prev = 0;
    for (int i = 0; i < 9; i++) begin
      run_conv(prev, CODES[i], i == 8);
      prev = shift_for(CODES[i]);
    end
    run_conv(prev, 3'h0, 1'b0);
    summarize();
  end
endmodule

`default_nettype wire
